// ===== verilog/jpeg_host_pkg.sv
// Package for the decoder host register bank: offsets, status bits, carriers.
// Assumes one core clock and a word-addressed Wishbone slave port.
package jpeg_host_pkg;
    localparam int DATA_W = 32;
    localparam int ADR_W = 4;
    localparam int SEL_W = 4;
    localparam int STAT_W = 9;
    localparam int MASK_W = 9;
    localparam int COORD_W = 16;

    // Register indices on the 4-bit address
    localparam logic [3:0] ADR_STATUS = 4'h0;
    localparam logic [3:0] ADR_MASK = 4'h1;
    localparam logic [3:0] ADR_SIZE_X = 4'h2;
    localparam logic [3:0] ADR_SIZE_Y = 4'h3;
    localparam logic [3:0] ADR_LEFT = 4'h4;
    localparam logic [3:0] ADR_TOP = 4'h5;
    localparam logic [3:0] ADR_RIGHT = 4'h6;
    localparam logic [3:0] ADR_BOTTOM = 4'h7;
    localparam logic [3:0] ADR_RD_PTR = 4'h8;
    localparam logic [3:0] ADR_RD_CNT = 4'h9;
    localparam logic [3:0] ADR_WIN_LOW = 4'ha;
    localparam logic [3:0] ADR_WIN_HIGH = 4'hb;
    localparam logic [3:0] ADR_SHIFT = 4'hc;
    localparam logic [3:0] ADR_LINE_W = 4'hd;
    localparam logic [3:0] ADR_WR_POS = 4'he;

    // Status bit positions
    localparam int ST_READY = 0;
    localparam int ST_IN_EMPTY = 1;
    localparam int ST_WIN_FULL = 2;
    localparam int ST_ERROR = 3;
    localparam int ST_NOT_JPEG = 4;
    localparam int ST_CORRUPT = 5;
    localparam int ST_UNSUP = 6;
    localparam int ST_START = 7;
    localparam int ST_IDLE = 8;

    localparam logic [STAT_W-1:0] STATUS_RESET = 9'h100;
    localparam logic [STAT_W-1:0] CLR_LOW_FLAGS = 9'h07f;
    localparam logic [DATA_W-1:0] EVEN_MASK = 32'hffff_fffe;
    localparam logic [DATA_W-1:0] WORD_MASK = 32'hffff_fffc;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADR_W-1:0] adr;
        logic [SEL_W-1:0] sel;
        logic [DATA_W-1:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic ready;
        logic in_empty;
        logic win_full;
        logic not_jpeg;
        logic corrupt;
        logic unsupported;
        logic byte_taken;
    } engine_ev_t;

    typedef struct packed {
        logic [MASK_W-1:0] mask;
        logic [COORD_W-1:0] left;
        logic [COORD_W-1:0] top;
        logic [COORD_W-1:0] right;
        logic [COORD_W-1:0] bottom;
        logic [DATA_W-1:0] rd_ptr;
        logic [DATA_W-1:0] rd_cnt;
        logic [DATA_W-1:0] win_low;
        logic [DATA_W-1:0] win_high;
        logic [DATA_W-1:0] shift;
        logic [COORD_W-1:0] line_w;
    } cfg_t;

    typedef struct packed {
        logic start;
        logic soft_reset;
        logic resume_in;
        logic resume_out;
    } cmd_t;
endpackage

// ===== verilog/wb_handshake.sv
// Wishbone slave handshake: takes one access, answers with a one-cycle ack.
// Assumes the master holds cyc, stb and the request until it sees ack.
`timescale 1ns/1ns
module wb_handshake
    import jpeg_host_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire wb_req_t req,
    output logic take,
    output logic ack
);
    typedef struct packed {
        logic ack;
    } hs_state_t;

    hs_state_t st;
    hs_state_t next_st;

    // Request is taken on the edge that raises ack
    assign take = req.cyc && req.stb && !st.ack;
    assign ack = st.ack;

    always_comb begin
        next_st = st;
        next_st.ack = take;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    a_ack_single: assert property (@(posedge core_clk) disable iff (srst)
        st.ack |=> !st.ack)
        else $error("ack held longer than one cycle");

    a_ack_follows_req: assert property (@(posedge core_clk) disable iff (srst)
        (req.cyc && req.stb && !st.ack) |=> st.ack)
        else $error("request not acknowledged");
endmodule

// ===== verilog/status_flags.sv
// Status flags and interrupt line of the decoder host interface.
// Assumes engine events are same-clock pulses and cmd bits are lane-gated.
`timescale 1ns/1ns
module status_flags
    import jpeg_host_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic wr_status,
    input wire logic [STAT_W-1:0] wr_bits,
    input wire engine_ev_t ev,
    input wire logic [MASK_W-1:0] mask,
    output logic [STAT_W-1:0] status,
    output logic irq
);
    typedef struct packed {
        logic [STAT_W-1:0] status;
        logic irq;
    } flag_state_t;

    flag_state_t st;
    flag_state_t next_st;

    assign status = st.status;
    assign irq = st.irq;

    always_comb begin
        next_st = st;
        if (wr_status) begin
            if (wr_bits[ST_IDLE]) begin
                next_st.status = st.status & ~CLR_LOW_FLAGS;
                next_st.status[ST_IDLE] = 1'b1;
            end
            if (wr_bits[ST_START]) begin
                next_st.status = next_st.status & ~CLR_LOW_FLAGS;
                next_st.status[ST_IDLE] = 1'b0;
            end
            if (wr_bits[ST_WIN_FULL]) begin
                next_st.status[ST_WIN_FULL] = 1'b0;
            end
            if (wr_bits[ST_IN_EMPTY]) begin
                next_st.status[ST_IN_EMPTY] = 1'b0;
            end
        end
        // Events win over a clear in the same cycle
        next_st.status[ST_READY] = next_st.status[ST_READY] | ev.ready;
        next_st.status[ST_IN_EMPTY] = next_st.status[ST_IN_EMPTY] | ev.in_empty;
        next_st.status[ST_WIN_FULL] = next_st.status[ST_WIN_FULL] | ev.win_full;
        next_st.status[ST_NOT_JPEG] = next_st.status[ST_NOT_JPEG] | ev.not_jpeg;
        next_st.status[ST_CORRUPT] = next_st.status[ST_CORRUPT] | ev.corrupt;
        next_st.status[ST_UNSUP] = next_st.status[ST_UNSUP] | ev.unsupported;
        next_st.status[ST_ERROR] = |next_st.status[ST_UNSUP:ST_NOT_JPEG];
        next_st.status[ST_START] = 1'b0;
        next_st.irq = |(next_st.status & mask);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st <= {STATUS_RESET, 1'b0};
        end else begin
            st <= next_st;
        end
    end

    a_error_global: assert property (@(posedge core_clk) disable iff (srst)
        st.status[ST_ERROR] == (|st.status[ST_UNSUP:ST_NOT_JPEG]))
        else $error("global error flag disagrees with specific flags");

    a_irq_follows: assert property (@(posedge core_clk) disable iff (srst)
        st.irq == (|(st.status & $past(mask))))
        else $error("interrupt line disagrees with masked status");

    a_start_leaves_idle: assert property (@(posedge core_clk) disable iff (srst)
        (wr_status && wr_bits[ST_START]) |=> !st.status[ST_IDLE])
        else $error("start did not clear idle flag");

    a_soft_reset_clear: assert property (@(posedge core_clk) disable iff (srst)
        (wr_status && wr_bits[ST_IDLE] && ev == '0) |=> st.status[ST_UNSUP:ST_IN_EMPTY] == '0)
        else $error("soft reset left low flags set");

    a_ready_holds: assert property (@(posedge core_clk) disable iff (srst)
        (st.status[ST_READY] && !(wr_status && (wr_bits[ST_IDLE] || wr_bits[ST_START])))
        |=> st.status[ST_READY])
        else $error("ready flag dropped without a clear");

    a_empty_holds: assert property (@(posedge core_clk) disable iff (srst)
        (st.status[ST_IN_EMPTY] && !(wr_status && (wr_bits[ST_IDLE]
        || wr_bits[ST_START] || wr_bits[ST_IN_EMPTY]))) |=> st.status[ST_IN_EMPTY])
        else $error("input empty flag dropped without a clear");

    a_full_clear: assert property (@(posedge core_clk) disable iff (srst)
        (wr_status && wr_bits[ST_WIN_FULL] && !ev.win_full) |=> !st.status[ST_WIN_FULL])
        else $error("window full flag not cleared");
endmodule

// ===== verilog/jpeg_host_regs.sv
// Host register bank of the baseline image decoder: Wishbone slave side.
// Assumes a word-addressing interconnect and a same-clock decode engine.
`timescale 1ns/1ns
//Contract
// - Interrupt cause holds until its flag clears
// - Ready flag holds until rst or start
// - Global error equals OR of specific errors
// - Rst or start clears all error flags
// - Idle flag holds; start clears it, starts
// - Data bit 8 soft reset clears bits 6..0
// - Data bit 7 clears idle, bits 6..0
// - Data bits 2,1 clear full, empty flags
// - Mask write loads data bits 8..0
// - Horizontal values stored even, bit 0 zero
// - Vertical values stored unchanged, 16 bits
// - Read pointer and count store 32 bits
// - Window and shift stored word aligned
// - Strobe and cycle capture data, raise ack
// - Ack seen: both ends drop their signals
// - Interrupt high when flag and mask set
module jpeg_host_regs
    import jpeg_host_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire wb_req_t wb_req,
    output logic [DATA_W-1:0] dat_o,
    output logic ack_o,
    output logic int_o,
    input wire engine_ev_t engine_ev,
    input wire logic [DATA_W-1:0] engine_wr_pos,
    input wire logic [COORD_W-1:0] image_width,
    input wire logic [COORD_W-1:0] image_height,
    output cfg_t cfg,
    output cmd_t cmd
);
    typedef struct packed {
        cfg_t cfg;
        cmd_t cmd;
        logic [DATA_W-1:0] rdata;
    } regs_state_t;

    regs_state_t st;
    regs_state_t next_st;
    logic take;
    logic wr_take;
    logic wr_status;
    logic [STAT_W-1:0] wr_bits;
    logic [STAT_W-1:0] status;
    logic [DATA_W-1:0] lane_mask;

    // Expands byte selects into a bit mask
    function automatic logic [DATA_W-1:0] lanes(input logic [SEL_W-1:0] sel);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < SEL_W; i++) begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        return m;
    endfunction

    // Merges selected bytes of new data into an old value
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] din, input logic [DATA_W-1:0] m);
        return (old & ~m) | (din & m);
    endfunction

    function automatic logic [DATA_W-1:0] widen(input logic [COORD_W-1:0] v);
        return {{(DATA_W-COORD_W){1'b0}}, v};
    endfunction

    wb_handshake u_handshake (
        .core_clk(core_clk),
        .srst(srst),
        .req(wb_req),
        .take(take),
        .ack(ack_o)
    );

    assign lane_mask = lanes(wb_req.sel);
    assign wr_take = take && wb_req.we;
    assign wr_status = wr_take && (wb_req.adr == ADR_STATUS);
    // Command bits only count in selected byte lanes
    assign wr_bits = wb_req.dat[STAT_W-1:0] & lane_mask[STAT_W-1:0];

    status_flags u_flags (
        .core_clk(core_clk),
        .srst(srst),
        .wr_status(wr_status),
        .wr_bits(wr_bits),
        .ev(engine_ev),
        // Next mask keeps int_o in step with a mask write
        .mask(next_st.cfg.mask),
        .status(status),
        .irq(int_o)
    );

    always_comb begin
        next_st = st;
        next_st.cmd = '0;
        // Engine consumes input bytes between host writes
        if (engine_ev.byte_taken) begin
            next_st.cfg.rd_ptr = st.cfg.rd_ptr + 32'h0000_0001;
            if (st.cfg.rd_cnt != ZERO_WORD) begin
                next_st.cfg.rd_cnt = st.cfg.rd_cnt - 32'h0000_0001;
            end
        end
        if (wr_take) begin
            unique case (wb_req.adr)
                ADR_STATUS: begin
                    next_st.cmd.soft_reset = wr_bits[ST_IDLE];
                    next_st.cmd.start = wr_bits[ST_START];
                    next_st.cmd.resume_in = wr_bits[ST_IN_EMPTY] && status[ST_IN_EMPTY];
                    next_st.cmd.resume_out = wr_bits[ST_WIN_FULL] && status[ST_WIN_FULL];
                end
                ADR_MASK: begin
                    next_st.cfg.mask =
                        MASK_W'(merge(widen({7'h00, st.cfg.mask}), wb_req.dat, lane_mask));
                end
                ADR_LEFT: begin
                    next_st.cfg.left = COORD_W'(
                        merge(widen(st.cfg.left), wb_req.dat, lane_mask) & EVEN_MASK);
                end
                ADR_TOP: begin
                    next_st.cfg.top =
                        COORD_W'(merge(widen(st.cfg.top), wb_req.dat, lane_mask));
                end
                ADR_RIGHT: begin
                    next_st.cfg.right = COORD_W'(
                        merge(widen(st.cfg.right), wb_req.dat, lane_mask) & EVEN_MASK);
                end
                ADR_BOTTOM: begin
                    next_st.cfg.bottom =
                        COORD_W'(merge(widen(st.cfg.bottom), wb_req.dat, lane_mask));
                end
                ADR_RD_PTR: begin
                    next_st.cfg.rd_ptr = merge(st.cfg.rd_ptr, wb_req.dat, lane_mask);
                end
                ADR_RD_CNT: begin
                    next_st.cfg.rd_cnt = merge(st.cfg.rd_cnt, wb_req.dat, lane_mask);
                end
                ADR_WIN_LOW: begin
                    next_st.cfg.win_low =
                        merge(st.cfg.win_low, wb_req.dat, lane_mask) & WORD_MASK;
                end
                ADR_WIN_HIGH: begin
                    next_st.cfg.win_high =
                        merge(st.cfg.win_high, wb_req.dat, lane_mask) & WORD_MASK;
                end
                ADR_SHIFT: begin
                    next_st.cfg.shift =
                        merge(st.cfg.shift, wb_req.dat, lane_mask) & WORD_MASK;
                end
                ADR_LINE_W: begin
                    next_st.cfg.line_w = COORD_W'(
                        merge(widen(st.cfg.line_w), wb_req.dat, lane_mask) & EVEN_MASK);
                end
                default: begin
                    // Read-only or unmapped: acknowledged, nothing stored
                    next_st.cfg = next_st.cfg;
                end
            endcase
        end
        // Read data is captured on the edge that raises ack
        if (take && !wb_req.we) begin
            unique case (wb_req.adr)
                ADR_STATUS: next_st.rdata = {23'h000000, status};
                ADR_MASK: next_st.rdata = {23'h000000, st.cfg.mask};
                ADR_SIZE_X: next_st.rdata = widen(image_width);
                ADR_SIZE_Y: next_st.rdata = widen(image_height);
                ADR_LEFT: next_st.rdata = widen(st.cfg.left);
                ADR_TOP: next_st.rdata = widen(st.cfg.top);
                ADR_RIGHT: next_st.rdata = widen(st.cfg.right);
                ADR_BOTTOM: next_st.rdata = widen(st.cfg.bottom);
                ADR_RD_PTR: next_st.rdata = st.cfg.rd_ptr;
                ADR_RD_CNT: next_st.rdata = st.cfg.rd_cnt;
                ADR_WIN_LOW: next_st.rdata = st.cfg.win_low;
                ADR_WIN_HIGH: next_st.rdata = st.cfg.win_high;
                ADR_SHIFT: next_st.rdata = st.cfg.shift;
                ADR_LINE_W: next_st.rdata = widen(st.cfg.line_w);
                ADR_WR_POS: next_st.rdata = engine_wr_pos & WORD_MASK;
                default: next_st.rdata = ZERO_WORD;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cfg = st.cfg;
    assign cmd = st.cmd;
    assign dat_o = st.rdata;

    a_even_coords: assert property (@(posedge core_clk) disable iff (srst)
        (wr_take && wb_req.adr == ADR_LEFT && wb_req.sel == 4'hf)
        |=> st.cfg.left == {$past(wb_req.dat[COORD_W-1:1]), 1'b0})
        else $error("horizontal start not stored even");

    a_vert_store: assert property (@(posedge core_clk) disable iff (srst)
        (wr_take && wb_req.adr == ADR_BOTTOM && wb_req.sel == 4'hf)
        |=> st.cfg.bottom == $past(wb_req.dat[COORD_W-1:0]))
        else $error("vertical end not stored unchanged");

    a_count_store: assert property (@(posedge core_clk) disable iff (srst)
        (wr_take && wb_req.adr == ADR_RD_CNT && wb_req.sel == 4'hf)
        |=> st.cfg.rd_cnt == $past(wb_req.dat))
        else $error("input byte count not stored");

    a_word_align: assert property (@(posedge core_clk) disable iff (srst)
        (wr_take && wb_req.adr == ADR_SHIFT && wb_req.sel == 4'hf)
        |=> st.cfg.shift == {$past(wb_req.dat[DATA_W-1:2]), 2'b00})
        else $error("output shift not word aligned");

    a_mask_load: assert property (@(posedge core_clk) disable iff (srst)
        (wr_take && wb_req.adr == ADR_MASK && wb_req.sel == 4'hf)
        |=> st.cfg.mask == $past(wb_req.dat[MASK_W-1:0]))
        else $error("mask not loaded from data bits 8 to 0");

    a_start_pulse: assert property (@(posedge core_clk) disable iff (srst)
        (wr_status && wr_bits[ST_START]) |=> (cmd.start && ack_o) ##1 !cmd.start)
        else $error("start pulse missing or too long");

    a_right_even: assert property (@(posedge core_clk) disable iff (srst)
        (wr_take && wb_req.adr == ADR_RIGHT && wb_req.sel == 4'hf)
        |=> st.cfg.right == {$past(wb_req.dat[COORD_W-1:1]), 1'b0})
        else $error("horizontal end not stored even");

    a_width_even: assert property (@(posedge core_clk) disable iff (srst)
        (wr_take && wb_req.adr == ADR_LINE_W && wb_req.sel == 4'hf)
        |=> st.cfg.line_w == {$past(wb_req.dat[COORD_W-1:1]), 1'b0})
        else $error("line width not stored even");

    a_top_store: assert property (@(posedge core_clk) disable iff (srst)
        (wr_take && wb_req.adr == ADR_TOP && wb_req.sel == 4'hf)
        |=> st.cfg.top == $past(wb_req.dat[COORD_W-1:0]))
        else $error("vertical start not stored unchanged");

    a_ptr_store: assert property (@(posedge core_clk) disable iff (srst)
        (wr_take && wb_req.adr == ADR_RD_PTR && wb_req.sel == 4'hf)
        |=> st.cfg.rd_ptr == $past(wb_req.dat))
        else $error("input read pointer not stored");

    a_low_align: assert property (@(posedge core_clk) disable iff (srst)
        (wr_take && wb_req.adr == ADR_WIN_LOW && wb_req.sel == 4'hf)
        |=> st.cfg.win_low == {$past(wb_req.dat[DATA_W-1:2]), 2'b00})
        else $error("window start not word aligned");

    a_high_align: assert property (@(posedge core_clk) disable iff (srst)
        (wr_take && wb_req.adr == ADR_WIN_HIGH && wb_req.sel == 4'hf)
        |=> st.cfg.win_high == {$past(wb_req.dat[DATA_W-1:2]), 2'b00})
        else $error("window end not word aligned");

    a_soft_pulse: assert property (@(posedge core_clk) disable iff (srst)
        (wr_status && wr_bits[ST_IDLE]) |=> cmd.soft_reset)
        else $error("soft reset pulse missing");

    a_resume_out: assert property (@(posedge core_clk) disable iff (srst)
        (wr_status && wr_bits[ST_WIN_FULL] && status[ST_WIN_FULL]) |=> cmd.resume_out)
        else $error("window resume pulse missing");

    a_ro_ignored: assert property (@(posedge core_clk) disable iff (srst)
        (wr_take && (wb_req.adr == ADR_WR_POS || wb_req.adr == ADR_SIZE_X)
        && !engine_ev.byte_taken) |=> $stable(st.cfg))
        else $error("read-only write changed a register");
endmodule

// ===== testbench/wb_host_model.sv
// Host processor model driving the decoder's Wishbone slave port.
// Assumes a word-addressing interconnect and ack sampled on core_clk rise.
`timescale 1ns/1ns
module wb_host_model
    import jpeg_host_pkg::*;
#(
    parameter logic [23:0] BASE_ADDR = 24'h000400
)
(
    input wire logic core_clk,
    output wb_req_t wb_req,
    input wire logic ack_o,
    input wire logic [DATA_W-1:0] dat_o
);
    initial begin
        wb_req = '0;
    end

    // One bus access; ok stays low when no ack comes within the bound
    task automatic access(input logic we, input logic [3:0] idx, input logic [31:0] wdat,
                          output logic [31:0] rdat, output logic ok);
        logic [23:0] host_adr;
        int n;
        host_adr = BASE_ADDR + {18'h0, idx, 2'b00};
        ok = 1'b0;
        rdat = '0;
        @(posedge core_clk);
        #1;
        wb_req.adr = host_adr[5:2];
        wb_req.dat = wdat;
        wb_req.we = we;
        wb_req.sel = 4'hf;
        wb_req.cyc = 1'b1;
        wb_req.stb = 1'b1;
        for (n = 0; n < 16 && ok !== 1'b1; n++) begin
            @(posedge core_clk);
            if (ack_o === 1'b1) begin
                ok = 1'b1;
                rdat = dat_o;
            end
        end
        #1;
        wb_req.cyc = 1'b0;
        wb_req.stb = 1'b0;
        // Released lines must not keep the last value
        wb_req.adr = ~wb_req.adr;
        wb_req.dat = ~wb_req.dat;
    endtask
endmodule

// ===== testbench/tb_jpeg_host_regs.sv
// Self-checking bench for the decoder host register bank.
// Assumes the host model above and engine events driven from here.
`timescale 1ns/1ns
module tb_jpeg_host_regs
    import jpeg_host_pkg::*;
();
    typedef struct packed {
        logic [3:0] idx;
        logic [31:0] wdat;
        logic [31:0] rexp;
    } row_t;

    logic core_clk;
    logic srst;
    wb_req_t wb_req;
    logic [DATA_W-1:0] dat_o;
    logic ack_o;
    logic int_o;
    engine_ev_t engine_ev;
    cfg_t cfg;
    cmd_t cmd;
    int n_fail = 0;
    int checks_done = 0;
    int n_acc = 0;
    int n_ack = 0;
    int n_long = 0;
    int n_start = 0;
    int n_rin = 0;
    int n_rout = 0;
    int n_srst = 0;
    logic ack_prev = 1'b0;
    row_t rows[15] = '{
        '{4'h1, 32'hffff_ffff, 32'h0000_01ff},
        '{4'h4, 32'hffff_ffff, 32'h0000_fffe},
        '{4'h5, 32'hffff_abcd, 32'h0000_abcd},
        '{4'h6, 32'h1234_5679, 32'h0000_5678},
        '{4'h7, 32'h0000_8001, 32'h0000_8001},
        '{4'h8, 32'hdead_beef, 32'hdead_beef},
        '{4'h9, 32'h0000_0003, 32'h0000_0003},
        '{4'ha, 32'hffff_ffff, 32'hffff_fffc},
        '{4'hb, 32'h1234_5677, 32'h1234_5674},
        '{4'hc, 32'h0000_0006, 32'h0000_0004},
        '{4'hd, 32'h0000_0031, 32'h0000_0030},
        '{4'h2, 32'h0000_1234, 32'h0000_0050},
        '{4'h3, 32'h0000_1234, 32'h0000_0077},
        '{4'he, 32'hffff_ffff, 32'h0000_1234},
        '{4'hf, 32'hffff_ffff, 32'h0000_0000}
    };

    jpeg_host_regs dut (
        .core_clk(core_clk),
        .srst(srst),
        .wb_req(wb_req),
        .dat_o(dat_o),
        .ack_o(ack_o),
        .int_o(int_o),
        .engine_ev(engine_ev),
        .engine_wr_pos(32'h0000_1237),
        .image_width(16'h0050),
        .image_height(16'h0077),
        .cfg(cfg),
        .cmd(cmd)
    );

    wb_host_model host (
        .core_clk(core_clk),
        .wb_req(wb_req),
        .ack_o(ack_o),
        .dat_o(dat_o)
    );

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (cmd.start === 1'b1) n_start++;
        if (cmd.resume_in === 1'b1) n_rin++;
        if (cmd.resume_out === 1'b1) n_rout++;
        if (cmd.soft_reset === 1'b1) n_srst++;
        if (ack_o === 1'b1) n_ack++;
        if (ack_o === 1'b1 && ack_prev === 1'b1) n_long++;
        ack_prev = ack_o;
    end

    task automatic final_report();
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic acc(input logic we, input logic [3:0] idx, input logic [31:0] d,
                       output logic [31:0] r);
        logic ok;
        n_acc++;
        host.access(we, idx, d, r, ok);
        if (ok !== 1'b1) begin
            n_fail++;
            final_report();
        end
    endtask

    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        logic [31:0] r;
        acc(1'b1, idx, d, r);
    endtask

    task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        acc(1'b0, idx, 32'h0, r);
        check(r, exp);
    endtask

    task automatic pulse(input engine_ev_t e);
        @(posedge core_clk);
        #1;
        engine_ev = e;
        @(posedge core_clk);
        #1;
        engine_ev = '0;
    endtask

    task automatic int_chk(input logic exp);
        repeat (2) @(posedge core_clk);
        #1;
        check({31'h0, int_o}, {31'h0, exp});
    endtask

    initial begin
        srst = 1'b1;
        engine_ev = '0;
        repeat (6) @(posedge core_clk);
        #1;
        srst = 1'b0;
        check({31'h0, (cfg === '0)}, 32'h1);
        check({31'h0, int_o}, 32'h0);
        rd_chk(ADR_STATUS, 32'h0000_0100);
        foreach (rows[i]) begin
            wr(rows[i].idx, rows[i].wdat);
            rd_chk(rows[i].idx, rows[i].rexp);
        end
        check(32'(cfg.line_w), 32'h0000_0030);
        int_chk(1'b1);
        wr(ADR_MASK, 32'h0);
        int_chk(1'b0);
        wr(ADR_MASK, 32'h1ff);
        wr(ADR_STATUS, 32'h80);
        rd_chk(ADR_STATUS, 32'h0);
        check(32'(n_start), 32'h1);
        int_chk(1'b0);
        // Error flags and the global error bit
        pulse('{not_jpeg: 1'b1, default: 1'b0});
        rd_chk(ADR_STATUS, 32'h18);
        pulse('{corrupt: 1'b1, default: 1'b0});
        rd_chk(ADR_STATUS, 32'h38);
        wr(ADR_STATUS, 32'h02);
        rd_chk(ADR_STATUS, 32'h38);
        check(32'(n_rin), 32'h0);
        wr(ADR_STATUS, 32'h80);
        rd_chk(ADR_STATUS, 32'h0);
        pulse('{unsupported: 1'b1, default: 1'b0});
        rd_chk(ADR_STATUS, 32'h48);
        int_chk(1'b1);
        wr(ADR_STATUS, 32'h100);
        rd_chk(ADR_STATUS, 32'h100);
        // Ready holds until soft reset or start
        wr(ADR_STATUS, 32'h80);
        pulse('{ready: 1'b1, default: 1'b0});
        repeat (20) @(posedge core_clk);
        rd_chk(ADR_STATUS, 32'h1);
        int_chk(1'b1);
        wr(ADR_STATUS, 32'h80);
        rd_chk(ADR_STATUS, 32'h0);
        pulse('{ready: 1'b1, default: 1'b0});
        wr(ADR_STATUS, 32'h100);
        rd_chk(ADR_STATUS, 32'h100);
        // Input exhausted and window full, with a narrow mask
        wr(ADR_STATUS, 32'h80);
        wr(ADR_MASK, 32'h002);
        pulse('{in_empty: 1'b1, default: 1'b0});
        rd_chk(ADR_STATUS, 32'h2);
        int_chk(1'b1);
        wr(ADR_RD_PTR, 32'h0000_2000);
        wr(ADR_RD_CNT, 32'h0000_0100);
        wr(ADR_STATUS, 32'h02);
        rd_chk(ADR_STATUS, 32'h0);
        check(32'(n_rin), 32'h1);
        int_chk(1'b0);
        pulse('{win_full: 1'b1, default: 1'b0});
        int_chk(1'b0);
        wr(ADR_WIN_LOW, 32'h0000_4000);
        wr(ADR_STATUS, 32'h04);
        rd_chk(ADR_STATUS, 32'h0);
        check(32'(n_rout), 32'h1);
        pulse('{in_empty: 1'b1, win_full: 1'b1, default: 1'b0});
        wr(ADR_SHIFT, 32'h0000_0010);
        wr(ADR_STATUS, 32'h04);
        rd_chk(ADR_STATUS, 32'h2);
        // Engine consumes one input byte
        pulse('{byte_taken: 1'b1, default: 1'b0});
        rd_chk(ADR_RD_PTR, 32'h0000_2001);
        rd_chk(ADR_RD_CNT, 32'h0000_00ff);
        check(32'(n_start), 32'h5);
        check(32'(n_srst), 32'h2);
        // Reset in mid-run, interrupt pending
        @(posedge core_clk);
        #1;
        srst = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        srst = 1'b0;
        check({31'h0, (cfg === '0)}, 32'h1);
        check({31'h0, int_o}, 32'h0);
        rd_chk(ADR_STATUS, 32'h0000_0100);
        check(32'(n_ack), 32'(n_acc));
        check(32'(n_long), 32'h0);
        final_report();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        final_report();
    end
endmodule
